// file: rtl/bcx_pkg.sv
// shared constants and types of the branch/control execution unit
package bcx_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses on the apb bus)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INSTR = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0C;
	localparam logic [7:0] OFS_PSW = 8'h10;
	localparam logic [7:0] OFS_ACC = 8'h14;
	localparam logic [7:0] OFS_BC = 8'h18;
	localparam logic [7:0] OFS_HL = 8'h1C;
	localparam logic [7:0] OFS_SP = 8'h20;
	localparam logic [7:0] OFS_MADDR = 8'h24;
	localparam logic [7:0] OFS_MDATA = 8'h28;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_CLK_LSB = 0;
	localparam int CTRL_WAKE_BIT = 8;
	localparam int INS_OP_LSB = 0;
	localparam int INS_MODE_LSB = 4;
	localparam int INS_BIT_LSB = 8;
	localparam int INS_ADDR_LSB = 16;
	localparam int INS_OFS_LSB = 24;
	localparam int ST_BUSY = 0, ST_HALT = 1, ST_STOP = 2, ST_TAKEN = 3, ST_IE = 4, ST_CYC_LSB = 8;
	localparam int PSW_IE = 7, PSW_Z = 6, PSW_BANK_SELECT_BITS = 5, PSW_AC = 4, PSW_RBS0 = 3, PSW_CY = 0;

	////////////////////////////////////////////////////////////////////////
	// reset values and memory map
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h00F0;
	localparam logic [15:0] HL_RST = 16'h0000;
	localparam logic [7:0] PSW_RST = 8'h02;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] HSRAM_TOP = 8'hDF;
	localparam logic [7:0] VEC_LO = 8'h3E;
	localparam logic [7:0] VEC_HI = 8'h3F;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] TWO16 = 16'h0002;
	localparam logic [15:0] THREE16 = 16'h0003;

	////////////////////////////////////////////////////////////////////////
	// instruction lengths and cycle counts
	localparam logic [2:0] LEN1 = 3'h1, LEN2 = 3'h2, LEN3 = 3'h3, LEN4 = 3'h4;
	localparam logic [3:0] CYC2 = 4'h2, CYC4 = 4'h4, CYC6 = 4'h6, CYC8 = 4'h8, CYC9 = 4'h9;
	localparam logic [3:0] CYC10 = 4'hA, CYC11 = 4'hB, CYC12 = 4'hC;

	////////////////////////////////////////////////////////////////////////
	// operations and operand forms
	typedef enum logic [3:0] {
		OP_NOP = 4'b0000,
		OP_BSET = 4'b0001,
		OP_BCLR = 4'b0010,
		OP_BTCL = 4'b0011,
		OP_DECREMENT_BRANCH_NONZERO = 4'b0100,
		OP_SEL = 4'b0101,
		OP_EI = 4'b0110,
		OP_DI = 4'b0111,
		OP_HALT = 4'b1000,
		OP_STOP = 4'b1001,
		OP_BRK = 4'b1010
	} bcx_op_t;

	typedef enum logic [2:0] {
		M_SADDR = 3'b000,
		M_SFR = 3'b001,
		M_ACC = 3'b010,
		M_PSW = 3'b011,
		M_HL = 3'b100,
		M_B = 3'b101,
		M_C = 3'b110
	} bcx_mode_t;

endpackage

// file: rtl/bcx_clkdiv.sv
// cpu clock enable divider steered by the processor clock control field
module bcx_clkdiv (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// divider select
	input wire logic [1:0] clk_sel,
	// one-cycle cpu clock enable
	output logic cpu_en
);

	typedef struct packed {
		logic [2:0] cnt;
	} bcx_div_t;

	bcx_div_t s;
	bcx_div_t next_s;
	logic [2:0] mask;

	always_comb begin
		next_s = s;
		next_s.cnt = s.cnt + 3'h1;
		case (clk_sel)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			default: mask = 3'h7;
		endcase
	end

	// one enable pulse is one instruction clock cycle
	assign cpu_en = (s.cnt & mask) == mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

// file: rtl/bcx_timing.sv
// length and cycle lookup per operation and operand form
module bcx_timing (
	// decoded request
	input wire bcx_pkg::bcx_op_t op,
	input wire bcx_pkg::bcx_mode_t mode,
	input wire logic slow,
	// results
	output logic [2:0] len,
	output logic [3:0] cyc,
	output logic legal
);

	// counts assume program fetch from internal rom
	always_comb begin
		len = bcx_pkg::LEN2;
		cyc = bcx_pkg::CYC6;
		legal = 1'b1;
		case (op)
			bcx_pkg::OP_BSET, bcx_pkg::OP_BCLR, bcx_pkg::OP_BTCL: begin
				case (mode)
					bcx_pkg::M_SADDR: begin
						len = (op == bcx_pkg::OP_BSET) ? bcx_pkg::LEN3 : bcx_pkg::LEN4;
						if (op == bcx_pkg::OP_BSET) begin
							cyc = slow ? bcx_pkg::CYC9 : bcx_pkg::CYC8;
						end else if (op == bcx_pkg::OP_BCLR) begin
							cyc = slow ? bcx_pkg::CYC11 : bcx_pkg::CYC10;
						end else begin
							cyc = slow ? bcx_pkg::CYC12 : bcx_pkg::CYC10;
						end
					end
					bcx_pkg::M_SFR: begin
						len = bcx_pkg::LEN4;
						cyc = (op == bcx_pkg::OP_BTCL) ? bcx_pkg::CYC12 : bcx_pkg::CYC11;
					end
					bcx_pkg::M_ACC: begin
						len = bcx_pkg::LEN3;
						cyc = bcx_pkg::CYC8;
					end
					bcx_pkg::M_PSW: begin
						len = (op == bcx_pkg::OP_BSET) ? bcx_pkg::LEN3 : bcx_pkg::LEN4;
						if (op == bcx_pkg::OP_BSET) begin
							cyc = bcx_pkg::CYC9;
						end else if (op == bcx_pkg::OP_BCLR) begin
							cyc = bcx_pkg::CYC11;
						end else begin
							cyc = bcx_pkg::CYC12;
						end
					end
					bcx_pkg::M_HL: begin
						len = bcx_pkg::LEN3;
						if (!slow) begin
							cyc = bcx_pkg::CYC10;
						end else begin
							cyc = (op == bcx_pkg::OP_BTCL) ? bcx_pkg::CYC12 : bcx_pkg::CYC11;
						end
					end
					default: legal = 1'b0;
				endcase
			end
			bcx_pkg::OP_DECREMENT_BRANCH_NONZERO: begin
				case (mode)
					bcx_pkg::M_B, bcx_pkg::M_C: begin
						len = bcx_pkg::LEN2;
						cyc = bcx_pkg::CYC6;
					end
					bcx_pkg::M_SADDR: begin
						len = bcx_pkg::LEN3;
						cyc = slow ? bcx_pkg::CYC10 : bcx_pkg::CYC8;
					end
					default: legal = 1'b0;
				endcase
			end
			bcx_pkg::OP_SEL: cyc = bcx_pkg::CYC4;
			bcx_pkg::OP_NOP: begin
				len = bcx_pkg::LEN1;
				cyc = bcx_pkg::CYC2;
			end
			bcx_pkg::OP_BRK: len = bcx_pkg::LEN1;
			bcx_pkg::OP_EI, bcx_pkg::OP_DI, bcx_pkg::OP_HALT, bcx_pkg::OP_STOP: cyc = bcx_pkg::CYC6;
			default: legal = 1'b0;
		endcase
	end

endmodule

// file: rtl/bcx_exec.sv
// branch, loop and cpu control execution unit with apb register access
//
// Notes on behaviour
// - one instruction cycle is one cpu clock period
// - slow counts apply outside high-speed ram
// - counts assume fetch from internal rom
// - bit-set branch on saddr: three bytes
// - bit-set branch on sfr: four bytes, 11
// - bit-clear branch on saddr: four bytes, 10/11
// - bit-clear branch on accumulator: three bytes, 8
// - bit-clear branch via hl: three bytes, 10/11
// - branch-and-clear: branch and clear when set
// - clearing a status bit may change flags
// - b/c decrement then branch if nonzero
// - saddr byte decrement, write back, branch
// - enable op sets master interrupt enable
// - disable op clears master interrupt enable
// - halt op enters halt standby
// - stop op enters stop standby
// - break pushes status and return, vectors
//
// Implementation choices: the address map and the APB register port.
module bcx_exec (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core state seen from outside
	output logic busy,
	output logic halt_mode,
	output logic stop_mode,
	output logic master_interrupt_enable
);

	typedef struct packed {
		logic [1:0] processor_clock_ctrl;
		logic busy;
		logic halt;
		logic stop;
		logic taken;
		bcx_pkg::bcx_op_t op;
		bcx_pkg::bcx_mode_t mode;
		logic [2:0] bitn;
		logic [7:0] addr;
		logic [7:0] signed_branch_offset;
		logic [2:0] len;
		logic [3:0] cnt;
		logic [3:0] last_cyc;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] hl;
		logic [7:0] program_status_word;
		logic [7:0] acc;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] mem_addr;
		logic [31:0] rdata;
		logic [255:0][7:0] mem;
	} bcx_state_t;

	bcx_state_t s;
	bcx_state_t next_s;

	logic cpu_en;
	logic [2:0] iss_len;
	logic [3:0] iss_cyc;
	logic iss_legal;
	logic iss_slow;
	bcx_pkg::bcx_op_t iss_op;
	bcx_pkg::bcx_mode_t iss_mode;
	logic [7:0] iss_addr;

	logic [7:0] ea;
	logic [7:0] opnd;
	logic [7:0] wr_val;
	logic wr_en;
	logic bitv;
	logic go;
	logic [15:0] fall_pc;
	logic [15:0] target_pc;
	logic [15:0] ret_pc;
	logic [7:0] sp_lo;
	logic acc_phase;
	logic wr_acc;
	logic mapped;
	logic refused;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// sub-blocks

	bcx_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clk_sel(s.processor_clock_ctrl),
		.cpu_en(cpu_en)
	);

	bcx_timing u_tim (
		.op(iss_op),
		.mode(iss_mode),
		.slow(iss_slow),
		.len(iss_len),
		.cyc(iss_cyc),
		.legal(iss_legal)
	);

	////////////////////////////////////////////////////////////////////////
	// issue decode straight from the write data

	assign iss_op = bcx_pkg::bcx_op_t'(pwdata[bcx_pkg::INS_OP_LSB +: 4]);
	assign iss_mode = bcx_pkg::bcx_mode_t'(pwdata[bcx_pkg::INS_MODE_LSB +: 3]);
	assign iss_addr = (iss_mode == bcx_pkg::M_HL) ? s.hl[7:0] : pwdata[bcx_pkg::INS_ADDR_LSB +: 8];

	// sfr and status word never sit in high-speed ram
	always_comb begin
		case (iss_mode)
			bcx_pkg::M_SFR, bcx_pkg::M_PSW: iss_slow = 1'b1;
			bcx_pkg::M_SADDR, bcx_pkg::M_HL: iss_slow = iss_addr > bcx_pkg::HSRAM_TOP;
			default: iss_slow = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode

	assign acc_phase = psel && penable;
	assign wr_acc = acc_phase && pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_mux = '0;
		case (paddr)
			bcx_pkg::OFS_CTRL: rd_mux[bcx_pkg::CTRL_CLK_LSB +: 2] = s.processor_clock_ctrl;
			bcx_pkg::OFS_INSTR: begin
				rd_mux[bcx_pkg::INS_OP_LSB +: 4] = s.op;
				rd_mux[bcx_pkg::INS_MODE_LSB +: 3] = s.mode;
				rd_mux[bcx_pkg::INS_BIT_LSB +: 3] = s.bitn;
				rd_mux[bcx_pkg::INS_ADDR_LSB +: 8] = s.addr;
				rd_mux[bcx_pkg::INS_OFS_LSB +: 8] = s.signed_branch_offset;
			end
			bcx_pkg::OFS_STATUS: begin
				rd_mux[bcx_pkg::ST_BUSY] = s.busy;
				rd_mux[bcx_pkg::ST_HALT] = s.halt;
				rd_mux[bcx_pkg::ST_STOP] = s.stop;
				rd_mux[bcx_pkg::ST_TAKEN] = s.taken;
				rd_mux[bcx_pkg::ST_IE] = s.program_status_word[bcx_pkg::PSW_IE];
				rd_mux[bcx_pkg::ST_CYC_LSB +: 4] = s.last_cyc;
			end
			bcx_pkg::OFS_PC: rd_mux[15:0] = s.pc;
			bcx_pkg::OFS_PSW: rd_mux[7:0] = s.program_status_word;
			bcx_pkg::OFS_ACC: rd_mux[7:0] = s.acc;
			bcx_pkg::OFS_BC: rd_mux[15:0] = {s.b, s.c};
			bcx_pkg::OFS_HL: rd_mux[15:0] = s.hl;
			bcx_pkg::OFS_SP: rd_mux[15:0] = s.sp;
			bcx_pkg::OFS_MADDR: rd_mux[7:0] = s.mem_addr;
			bcx_pkg::OFS_MDATA: rd_mux[7:0] = s.mem[s.mem_addr];
			default: mapped = 1'b0;
		endcase
	end

	// writes other than to ctrl and status are refused while the core is busy; issue is also refused in standby
	always_comb begin
		refused = 1'b0;
		if (pwrite && paddr != bcx_pkg::OFS_CTRL && paddr != bcx_pkg::OFS_STATUS) begin
			refused = s.busy;
		end
		if (pwrite && paddr == bcx_pkg::OFS_INSTR) begin
			refused = s.busy || s.halt || s.stop || !iss_legal;
		end
	end

	assign pready = 1'b1;
	assign pslverr = acc_phase && (!mapped || refused);

	////////////////////////////////////////////////////////////////////////
	// execution datapath

	assign go = s.busy && cpu_en && s.cnt == 4'h1;
	assign ea = (s.mode == bcx_pkg::M_HL) ? s.hl[7:0] : s.addr;
	assign bitv = opnd[s.bitn];
	assign fall_pc = s.pc + {13'h0000, s.len};
	// target is relative to the address after the whole instruction
	assign target_pc = fall_pc + {{8{s.signed_branch_offset[7]}}, s.signed_branch_offset};
	assign ret_pc = s.pc + bcx_pkg::ONE16;
	assign sp_lo = s.sp[7:0];

	always_comb begin
		case (s.mode)
			bcx_pkg::M_ACC: opnd = s.acc;
			bcx_pkg::M_PSW: opnd = s.program_status_word;
			bcx_pkg::M_B: opnd = s.b;
			bcx_pkg::M_C: opnd = s.c;
			default: opnd = s.mem[ea];
		endcase
	end

	always_comb begin
		next_s = s;
		wr_en = 1'b0;
		wr_val = opnd;
		next_s.rdata = s.rdata;

		// counting runs on the cpu clock enable only
		if (s.busy && cpu_en) begin
			next_s.cnt = s.cnt - 4'h1;
		end

		if (go) begin
			next_s.busy = 1'b0;
			next_s.taken = 1'b0;
			next_s.pc = fall_pc;
			case (s.op)
				bcx_pkg::OP_BSET: begin
					if (bitv) begin
						next_s.pc = target_pc;
						next_s.taken = 1'b1;
					end
				end
				bcx_pkg::OP_BCLR: begin
					if (!bitv) begin
						next_s.pc = target_pc;
						next_s.taken = 1'b1;
					end
				end
				bcx_pkg::OP_BTCL: begin
					if (bitv) begin
						next_s.pc = target_pc;
						next_s.taken = 1'b1;
						wr_en = 1'b1;
						// on the status word this may clear z, ac or cy
						wr_val = opnd & ~(8'h01 << s.bitn);
					end
				end
				bcx_pkg::OP_DECREMENT_BRANCH_NONZERO: begin
					wr_en = 1'b1;
					wr_val = opnd - 8'h01;
					if (wr_val != 8'h00) begin
						next_s.pc = target_pc;
						next_s.taken = 1'b1;
					end
				end
				bcx_pkg::OP_SEL: begin
					next_s.program_status_word[bcx_pkg::PSW_BANK_SELECT_BITS] = s.bitn[1];
					next_s.program_status_word[bcx_pkg::PSW_RBS0] = s.bitn[0];
				end
				bcx_pkg::OP_EI: next_s.program_status_word[bcx_pkg::PSW_IE] = 1'b1;
				bcx_pkg::OP_DI: next_s.program_status_word[bcx_pkg::PSW_IE] = 1'b0;
				bcx_pkg::OP_HALT: next_s.halt = 1'b1;
				bcx_pkg::OP_STOP: next_s.stop = 1'b1;
				bcx_pkg::OP_BRK: begin
					// old status word is pushed before enable is dropped
					next_s.mem[sp_lo - 8'h01] = s.program_status_word;
					next_s.mem[sp_lo - 8'h02] = ret_pc[15:8];
					next_s.mem[sp_lo - 8'h03] = ret_pc[7:0];
					next_s.pc = {s.mem[bcx_pkg::VEC_HI], s.mem[bcx_pkg::VEC_LO]};
					next_s.sp = s.sp - bcx_pkg::THREE16;
					next_s.program_status_word[bcx_pkg::PSW_IE] = 1'b0;
				end
				default: next_s.pc = fall_pc;
			endcase
		end

		// single write-back port keeps every form on the same path
		if (wr_en) begin
			case (s.mode)
				bcx_pkg::M_ACC: next_s.acc = wr_val;
				bcx_pkg::M_PSW: next_s.program_status_word = wr_val;
				bcx_pkg::M_B: next_s.b = wr_val;
				bcx_pkg::M_C: next_s.c = wr_val;
				default: next_s.mem[ea] = wr_val;
			endcase
		end

		////////////////////////////////////////////////////////////////////
		// register side

		if (psel && !penable) begin
			next_s.rdata = rd_mux;
		end

		if (wr_acc && mapped && !refused) begin
			case (paddr)
				bcx_pkg::OFS_CTRL: begin
					next_s.processor_clock_ctrl = pwdata[bcx_pkg::CTRL_CLK_LSB +: 2];
					// a standby entry landing on the same edge as the wake wins
					if (pwdata[bcx_pkg::CTRL_WAKE_BIT]) begin
						next_s.halt = go && s.op == bcx_pkg::OP_HALT;
						next_s.stop = go && s.op == bcx_pkg::OP_STOP;
					end
				end
				bcx_pkg::OFS_INSTR: begin
					next_s.op = iss_op;
					next_s.mode = iss_mode;
					next_s.bitn = pwdata[bcx_pkg::INS_BIT_LSB +: 3];
					next_s.addr = pwdata[bcx_pkg::INS_ADDR_LSB +: 8];
					next_s.signed_branch_offset = pwdata[bcx_pkg::INS_OFS_LSB +: 8];
					next_s.len = iss_len;
					next_s.cnt = iss_cyc;
					next_s.last_cyc = iss_cyc;
					next_s.busy = 1'b1;
				end
				bcx_pkg::OFS_PC: next_s.pc = pwdata[15:0];
				bcx_pkg::OFS_PSW: next_s.program_status_word = pwdata[7:0];
				bcx_pkg::OFS_ACC: next_s.acc = pwdata[7:0];
				bcx_pkg::OFS_BC: begin
					next_s.b = pwdata[15:8];
					next_s.c = pwdata[7:0];
				end
				bcx_pkg::OFS_HL: next_s.hl = pwdata[15:0];
				bcx_pkg::OFS_SP: next_s.sp = pwdata[15:0];
				bcx_pkg::OFS_MADDR: next_s.mem_addr = pwdata[7:0];
				bcx_pkg::OFS_MDATA: next_s.mem[s.mem_addr] = pwdata[7:0];
				default: next_s.rdata = s.rdata;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.pc <= bcx_pkg::PC_RST;
			s.sp <= bcx_pkg::SP_RST;
			s.hl <= bcx_pkg::HL_RST;
			s.program_status_word <= bcx_pkg::PSW_RST;
			s.acc <= bcx_pkg::BYTE_RST;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = s.rdata;
	assign busy = s.busy;
	assign halt_mode = s.halt;
	assign stop_mode = s.stop;
	assign master_interrupt_enable = s.program_status_word[bcx_pkg::PSW_IE];

endmodule

// file: test/bcx_exec_assertions.sv
// port-level checks of the branch and cpu control execution unit
module bcx_exec_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core state
	input wire logic busy,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic master_interrupt_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	logic [3:0] op_q;
	logic [1:0] sel_q;
	logic [5:0] cnt;
	logic wacc;
	assign wacc = psel && penable && pwrite && !pslverr;
	// only accepted writes count, refused ones leave the core alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= 4'h0;
			sel_q <= 2'h0;
			cnt <= 6'h00;
		end else begin
			if (wacc && paddr == bcx_pkg::OFS_INSTR) op_q <= pwdata[3:0];
			if (wacc && paddr == bcx_pkg::OFS_CTRL) sel_q <= pwdata[1:0];
			cnt <= busy ? cnt + 6'h01 : 6'h00;
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_start;
		wacc && paddr == bcx_pkg::OFS_INSTR |=> busy;
	endproperty
	a_start: assert property (p_start) else $error("accepted instruction did not start");
	property p_nop_cyc;
		$fell(busy) && op_q == 4'h0 && sel_q == 2'h0 |-> cnt == 6'd2;
	endproperty
	a_nop_cyc: assert property (p_nop_cyc) else $error("no-op length wrong");
	// free-running divider lets the first enable come up to div-1 cycles early
	property p_div_cyc;
		$fell(busy) && op_q == 4'h0 && sel_q == 2'h1 |-> cnt inside {6'd3, 6'd4};
	endproperty
	a_div_cyc: assert property (p_div_cyc) else $error("divided no-op length wrong");
	property p_ctl_cyc;
		$fell(busy) && sel_q == 2'h0 && op_q inside {[4'h5:4'h9]} |-> cnt == ((op_q == 4'h5) ? 6'd4 : 6'd6);
	endproperty
	a_ctl_cyc: assert property (p_ctl_cyc) else $error("control op length wrong");
	property p_ei;
		$fell(busy) && op_q == 4'h6 |-> master_interrupt_enable;
	endproperty
	a_ei: assert property (p_ei) else $error("enable op left interrupts off");
	property p_di;
		$fell(busy) && op_q == 4'h7 |-> !master_interrupt_enable;
	endproperty
	a_di: assert property (p_di) else $error("disable op left interrupts on");
	property p_halt;
		$fell(busy) && op_q == 4'h8 |-> halt_mode && !stop_mode;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not entered");
	property p_stop;
		$fell(busy) && op_q == 4'h9 |-> stop_mode && !halt_mode;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not entered");
	property p_brk;
		$fell(busy) && op_q == 4'hA |-> !master_interrupt_enable;
	endproperty
	a_brk: assert property (p_brk) else $error("break kept interrupts on");
	property p_halt_hold;
		halt_mode && !(wacc && paddr == bcx_pkg::OFS_CTRL && pwdata[8]) |=> halt_mode;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake");
	c_ei: cover property ($fell(busy) && op_q == 4'h6);
	c_wake: cover property (halt_mode ##1 !halt_mode);
	c_brk: cover property ($fell(busy) && op_q == 4'hA);
endmodule
bind bcx_exec bcx_exec_assertions u_bcx_exec_assertions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .busy, .halt_mode, .stop_mode, .master_interrupt_enable);

// file: test/bcx_apb_bfm.sv
// apb master model standing on the register bus side
module bcx_apb_bfm (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic err_s;
	logic err;
	logic [31:0] rdata;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// pslverr may move at the access edge, so keep its pre-edge value
	always @(posedge pclk) err_s <= pslverr;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(negedge pclk);
		err = err_s;
	endtask
endmodule

// file: test/cpu_branch_control_exec_test.sv
// self-checking bench of the branch and cpu control execution unit
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_branch_control_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, busy, halt_mode, stop_mode, master_interrupt_enable;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int errors = 0;
	int num_checks = 0;
	always #2 pclk = ~pclk;
	bcx_exec u_bcx_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .busy, .halt_mode, .stop_mode, .master_interrupt_enable);
	bcx_apb_bfm u_bcx_apb_bfm (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_bcx_apb_bfm.xfer(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		u_bcx_apb_bfm.xfer(1'b0, a, 32'h0000_0000);
		`CHK(u_bcx_apb_bfm.rdata, e)
	endtask
	task automatic mw(input logic [7:0] a, input logic [7:0] d);
		wr(bcx_pkg::OFS_MADDR, {24'h00_0000, a});
		wr(bcx_pkg::OFS_MDATA, {24'h00_0000, d});
	endtask
	task automatic mc(input logic [7:0] a, input logic [7:0] e);
		wr(bcx_pkg::OFS_MADDR, {24'h00_0000, a});
		rc(bcx_pkg::OFS_MDATA, {24'h00_0000, e});
	endtask
	// runs one op from pc 0100, polls busy, checks cycle count and next pc
	task automatic run(input logic [31:0] i, input logic [15:0] pce, input logic [3:0] cyc);
		logic [31:0] s;
		wr(bcx_pkg::OFS_PC, 32'h0000_0100);
		wr(bcx_pkg::OFS_INSTR, i);
		s = 32'h0000_0001;
		for (int k = 0; k < 40 && s[0] !== 1'b0; k++) begin
			u_bcx_apb_bfm.xfer(1'b0, bcx_pkg::OFS_STATUS, 32'h0000_0000);
			s = u_bcx_apb_bfm.rdata;
		end
		`CHK(s[0], 1'b0)
		`CHK(s[11:8], cyc)
		rc(bcx_pkg::OFS_PC, {16'h0000, pce});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_nop();
		rc(bcx_pkg::OFS_SP, 32'h0000_00F0);
		run(32'h0000_0000, 16'h0101, 4'h2);
		rc(bcx_pkg::OFS_PSW, 32'h0000_0002);
		u_bcx_apb_bfm.xfer(1'b0, 8'h2C, 32'h0000_0000);
		`CHK(u_bcx_apb_bfm.err, 1'b1)
		wr(bcx_pkg::OFS_CTRL, 32'h0000_0001);
		run(32'h0000_0000, 16'h0101, 4'h2);
		wr(bcx_pkg::OFS_CTRL, 32'h0000_0000);
	endtask
	task automatic t_bits();
		mw(8'h20, 8'h04);
		mw(8'hE5, 8'h02);
		mw(8'h30, 8'h04);
		wr(bcx_pkg::OFS_ACC, 32'h0000_007F);
		wr(bcx_pkg::OFS_HL, 32'h0000_0030);
		run(32'h1020_0201, 16'h0113, 4'h8);
		run(32'hF020_0301, 16'h0103, 4'h8);
		run(32'hFEE5_0111, 16'h0102, 4'hB);
		run(32'h20E0_0502, 16'h0124, 4'hB);
		run(32'h2020_0002, 16'h0124, 4'hA);
		run(32'h0800_0722, 16'h010B, 4'h8);
		run(32'h0400_0342, 16'h0107, 4'hA);
		run(32'h0400_0242, 16'h0103, 4'hA);
	endtask
	task automatic t_branch_and_clear_bit();
		mw(8'h40, 8'h08);
		run(32'h1040_0303, 16'h0114, 4'hA);
		mc(8'h40, 8'h00);
		run(32'h1040_0303, 16'h0104, 4'hA);
		wr(bcx_pkg::OFS_PSW, 32'h0000_0041);
		run(32'h1000_0033, 16'h0114, 4'hC);
		rc(bcx_pkg::OFS_PSW, 32'h0000_0040);
	endtask
	task automatic t_decrement_branch_nonzero();
		wr(bcx_pkg::OFS_BC, 32'h0000_0201);
		run(32'h1000_0054, 16'h0112, 4'h6);
		run(32'h1000_0064, 16'h0102, 4'h6);
		rc(bcx_pkg::OFS_BC, 32'h0000_0100);
		// decrement on the accumulator is no legal form and must be refused
		wr(bcx_pkg::OFS_INSTR, 32'h0000_0024);
		`CHK(u_bcx_apb_bfm.err, 1'b1)
		mw(8'h50, 8'h02);
		run(32'hF050_0004, 16'h00F3, 4'h8);
		mc(8'h50, 8'h01);
	endtask
	task automatic t_ctrl();
		wr(bcx_pkg::OFS_PSW, 32'h0000_0002);
		run(32'h0000_0305, 16'h0102, 4'h4);
		run(32'h0000_0006, 16'h0102, 4'h6);
		rc(bcx_pkg::OFS_PSW, 32'h0000_00AA);
		mw(8'h3E, 8'h34);
		mw(8'h3F, 8'h12);
		run(32'h0000_000A, 16'h1234, 4'h6);
		rc(bcx_pkg::OFS_SP, 32'h0000_00ED);
		mc(8'hEF, 8'hAA);
		mc(8'hED, 8'h01);
		`CHK(master_interrupt_enable, 1'b0)
		run(32'h0000_0006, 16'h0102, 4'h6);
		run(32'h0000_0007, 16'h0102, 4'h6);
		`CHK(master_interrupt_enable, 1'b0)
	endtask
	task automatic t_standby();
		run(32'h0000_0008, 16'h0102, 4'h6);
		wr(bcx_pkg::OFS_INSTR, 32'h0000_0000);
		`CHK(u_bcx_apb_bfm.err, 1'b1)
		`CHK(halt_mode, 1'b1)
		wr(bcx_pkg::OFS_CTRL, 32'h0000_0100);
		run(32'h0000_0009, 16'h0102, 4'h6);
		`CHK(halt_mode, 1'b0)
		wr(bcx_pkg::OFS_INSTR, 32'h0000_0000);
		`CHK(u_bcx_apb_bfm.err, 1'b1)
		wr(bcx_pkg::OFS_CTRL, 32'h0000_0100);
		`CHK(stop_mode, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_nop();
		t_bits();
		t_branch_and_clear_bit();
		t_decrement_branch_nonzero();
		t_ctrl();
		t_standby();
		final_report();
	end
	// a hung transfer would otherwise run forever
	initial begin
		#40000;
		errors++;
		final_report();
	end
endmodule
